// ---- diag_alarm_pkg.sv ----
// Purpose: Shared constants and carriers for the diagnostic status and alarm monitor.
// Assumes: Registers are 16 bits wide and sit at even byte addresses.
// Notes: Bit positions and masks are named here and used by name in the logic.
package diag_alarm_pkg;
	// ==========================================================
	// Register map
	localparam logic [6:0] OFS_THR1 = 7'h20;
	localparam logic [6:0] OFS_THR2 = 7'h22;
	localparam logic [6:0] OFS_CNT1 = 7'h24;
	localparam logic [6:0] OFS_CNT2 = 7'h26;
	localparam logic [6:0] OFS_CTRL = 7'h28;
	localparam logic [6:0] OFS_DIAG = 7'h3C;
	localparam logic [15:0] RST_VALUE = 16'h0000;
	// ==========================================================
	// Field layout
	localparam int DATA_W = 14;
	localparam int CNT_W = 8;
	localparam int THR_POL = 15;
	localparam logic [15:0] THR_MASK = 16'hBFFF;
	localparam logic [15:0] CNT_MASK = 16'h00FF;
	localparam logic [15:0] CTRL_MASK = 16'hFF17;
	localparam logic [15:0] FLAGS_MASK = 16'h037F;
	localparam int CTL_ROC1 = 11;
	localparam int CTL_SRC1 = 8;
	localparam int CTL_STRIDE = 4;
	localparam int CTL_FILT = 4;
	localparam int CTL_EN = 2;
	localparam int CTL_POL = 1;
	localparam int CTL_SEL = 0;
	localparam int FL_ALM1 = 8;
	localparam int FL_MEM = 6;
	localparam int FL_SELF = 5;
	localparam int FL_OVR = 4;
	localparam int FL_COMM = 3;
	localparam int FL_FLASH = 2;
	localparam int FL_SUP_HI = 1;
	localparam int FL_SUP_LO = 0;
	// ==========================================================
	// Alarm source codes
	localparam logic [2:0] SRC_SUPPLY = 3'h1;
	localparam logic [2:0] SRC_GYRO = 3'h2;
	localparam logic [2:0] SRC_AUX = 3'h5;
	localparam logic [2:0] SRC_TEMP = 3'h6;
	// ==========================================================
	// Carriers and states
	typedef struct packed {
		logic [DATA_W-1:0] supply;
		logic [DATA_W-1:0] gyro;
		logic [DATA_W-1:0] aux;
		logic [DATA_W-1:0] temp;
	} sample_set_t;
	typedef struct packed {
		logic self_test;
		logic overrange;
		logic comm;
		logic flash_update;
	} err_cond_t;
	typedef struct packed {
		logic [6:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} reg_req_t;
	typedef enum logic [1:0] {
		MT_IDLE = 2'h0,
		MT_RUN = 2'h1,
		MT_LAST = 2'h3,
		MT_DONE = 2'h2
	} memtest_state_t;
endpackage

// ---- diag_status_alarm_monitor.sv ----
// Purpose: Memory checksum test, clear-on-read diagnostic flags and two alarm monitors.
// Assumes: The register port and sensor data come from logic on the same clock;
//          flash and SRAM words arrive one cycle after their address.
// Notes: Only the supply comparator pins are synchronised.
`timescale 1ns/100ps
`default_nettype none

// What this block does
// - Memory-test request sums flash and SRAM, stores verdict in status bit 6.
// - Memory-test control bit clears itself once the comparison completes.
// - Status bit 6 reads one after a failed checksum, zero after a pass.
// - Reading the status register clears all its flags.
// - A persisting error sets its flag again at the next sample.
// - Supply flags drop by themselves once the supply is back in range.
// - Bit 1 flags supply above range, bit 0 supply below range.
// - Bits 9 and 8 report alarm 2 and alarm 1 active.
// - Bits 5 to 2 flag self-test, overrange, serial and flash update failures.
// - Two alarms run independently with own source, mode, threshold, count.
// - Threshold bit 15 picks above or below; bits 13 to 0 hold it.
// - Sample count lives in bits 7 to 0; zero and one both mean one.
// - Rate window spans the sample count times the sample period.
// - Control bits 15 and 11 choose rate-of-change or static level per alarm.
// - Source fields select off, supply, gyro, auxiliary ADC or temperature.
// - Control bit 4 selects filtered or unfiltered comparison data.
// - Control bits 2, 1, 0 enable, set polarity and route the indicator.
module diag_status_alarm_monitor #(
	parameter int MEM_WORDS = 64, // Words covered by the checksum, at least 2.
	parameter int MEM_AW = $clog2(MEM_WORDS) // Memory address width.
) (
	input wire logic clock, // 250 MHz clock.
	input wire logic rstn, // Asynchronous reset, active low.
	input wire logic sample_tick, // One-cycle pulse per sensor sample.
	input wire diag_alarm_pkg::reg_req_t reg_req, // Byte write or word read request.
	output logic [15:0] reg_rdata, // Read data, valid the cycle after a read.
	input wire logic memtest_request, // Pulse when the memory-test bit is written.
	output logic memtest_bit, // Memory-test control bit readback.
	output logic [MEM_AW-1:0] mem_addr, // Word index presented to flash and SRAM.
	input wire logic [15:0] flash_word, // Flash word for last cycle's index.
	input wire logic [15:0] sram_word, // SRAM word for last cycle's index.
	input wire logic supply_high_pin, // Comparator: supply above range.
	input wire logic supply_low_pin, // Comparator: supply below range.
	input wire diag_alarm_pkg::err_cond_t err_cond, // Live error conditions.
	input wire diag_alarm_pkg::sample_set_t raw_samples, // Unfiltered sources.
	input wire diag_alarm_pkg::sample_set_t filt_samples, // Filtered sources.
	output logic line_a_out, // First digital line level.
	output logic line_a_oe, // First digital line driven.
	output logic line_b_out, // Second digital line level.
	output logic line_b_oe // Second digital line driven.
);
	import diag_alarm_pkg::*;

	localparam int HIST = 2 ** CNT_W;
	localparam logic [MEM_AW-1:0] MEM_LAST = MEM_AW'(MEM_WORDS - 1);
	localparam int MT_SPAN = MEM_WORDS + 2;

	// ==========================================================
	// State
	typedef struct packed {
		logic [1:0][15:0] thr;
		logic [1:0][CNT_W-1:0] cnt;
		logic [15:0] ctrl;
		logic [15:0] flags;
		logic [1:0] alarm;
		logic [1:0][HIST-1:0][DATA_W-1:0] hist;
		logic [CNT_W-1:0] wp;
		memtest_state_t mt;
		logic [MEM_AW-1:0] idx;
		logic [15:0] sum_flash;
		logic [15:0] sum_sram;
		logic mem_fail;
		logic mt_bit;
		logic [2:0][1:0] sync;
		logic [1:0] sup;
		logic [15:0] rdata;
		logic a_out;
		logic a_oe;
		logic b_out;
		logic b_oe;
	} state_t;

	state_t st_q;
	state_t st_d;

	// ==========================================================
	// Helpers
	function automatic logic src_used(input logic [2:0] src);
		return src inside {SRC_SUPPLY, SRC_GYRO, SRC_AUX, SRC_TEMP};
	endfunction

	function automatic logic [DATA_W-1:0] pick(input logic [2:0] src, input sample_set_t s);
		case (src)
			SRC_SUPPLY: pick = s.supply;
			SRC_GYRO: pick = s.gyro;
			SRC_AUX: pick = s.aux;
			SRC_TEMP: pick = s.temp;
			default: pick = '0;
		endcase
	endfunction

	// Gyro and temperature are two's complement; supply and ADC are plain counts.
	function automatic logic signed [15:0] widen(input logic [2:0] src,
		input logic [DATA_W-1:0] v);
		if (src == SRC_GYRO || src == SRC_TEMP) begin
			widen = {{(16 - DATA_W){v[DATA_W-1]}}, v};
		end else begin
			widen = {{(16 - DATA_W){1'b0}}, v};
		end
	endfunction

	function automatic logic judge(input logic [15:0] thr, input logic roc,
		input logic [2:0] src, input logic [DATA_W-1:0] cur, input logic [DATA_W-1:0] old);
		logic signed [15:0] a;
		logic signed [15:0] t;
		logic signed [15:0] d;
		logic [15:0] mag;
		logic [15:0] lim;
		a = widen(src, cur);
		t = widen(src, thr[DATA_W-1:0]);
		d = a - widen(src, old);
		mag = d[15] ? 16'(-d) : 16'(d);
		lim = {{(16 - DATA_W){1'b0}}, thr[DATA_W-1:0]};
		if (!src_used(src)) begin
			judge = 1'b0;
		end else if (roc) begin
			judge = thr[THR_POL] ? (mag > lim) : (mag < lim);
		end else begin
			judge = thr[THR_POL] ? (a > t) : (a < t);
		end
	endfunction

	function automatic logic [15:0] merge(input logic [15:0] old, input logic hi,
		input logic [7:0] b, input logic [15:0] mask);
		return (hi ? {b, old[7:0]} : {old[15:8], b}) & mask;
	endfunction

	// ==========================================================
	// Alarm evaluation, one copy per alarm
	logic [1:0][2:0] alm_src;
	logic [1:0] alm_roc;
	logic [1:0][DATA_W-1:0] alm_cur;
	logic [1:0][DATA_W-1:0] alm_old;
	logic [1:0][CNT_W-1:0] alm_back;
	logic [1:0] alm_now;
	sample_set_t cmp_set;

	assign cmp_set = st_q.ctrl[CTL_FILT] ? filt_samples : raw_samples;

	for (genvar g = 0; g < 2; g++) begin : g_alarm
		assign alm_src[g] = st_q.ctrl[CTL_SRC1 + CTL_STRIDE * g +: 3];
		assign alm_roc[g] = st_q.ctrl[CTL_ROC1 + CTL_STRIDE * g];
		assign alm_cur[g] = pick(alm_src[g], cmp_set);
		assign alm_back[g] = (st_q.cnt[g] == '0) ? CNT_W'(1) : st_q.cnt[g];
		assign alm_old[g] = st_q.hist[g][CNT_W'(st_q.wp - alm_back[g])];
		assign alm_now[g] = judge(st_q.thr[g], alm_roc[g], alm_src[g],
			alm_cur[g], alm_old[g]);
	end

	logic ind_any;
	logic ind_lvl;
	logic diag_read;
	logic [6:0] word;

	assign ind_any = |st_q.alarm;
	assign ind_lvl = st_q.ctrl[CTL_POL] ? ind_any : !ind_any;
	assign diag_read = reg_req.rd && ({reg_req.addr[6:1], 1'b0} == OFS_DIAG);
	assign word = {reg_req.addr[6:1], 1'b0};

	// ==========================================================
	// Next state
	always_comb begin
		logic [15:0] set;
		logic en;
		set = '0;
		en = st_q.ctrl[CTL_EN];
		st_d = st_q;

		// Comparator pins: a level counts once the second and third stages agree.
		st_d.sync[0] = {supply_high_pin, supply_low_pin};
		st_d.sync[1] = st_q.sync[0];
		st_d.sync[2] = st_q.sync[1];
		for (int b = 0; b < 2; b++) begin
			if (st_q.sync[1][b] == st_q.sync[2][b]) begin
				st_d.sup[b] = st_q.sync[2][b];
			end
		end

		// Byte writes from the serial port; odd address is the upper byte.
		if (reg_req.wr) begin
			case (word)
				OFS_THR1: st_d.thr[0] = merge(st_q.thr[0], reg_req.addr[0], reg_req.wdata,
					THR_MASK);
				OFS_THR2: st_d.thr[1] = merge(st_q.thr[1], reg_req.addr[0], reg_req.wdata,
					THR_MASK);
				OFS_CNT1: st_d.cnt[0] = CNT_W'(merge({8'h00, st_q.cnt[0]}, reg_req.addr[0],
					reg_req.wdata, CNT_MASK));
				OFS_CNT2: st_d.cnt[1] = CNT_W'(merge({8'h00, st_q.cnt[1]}, reg_req.addr[0],
					reg_req.wdata, CNT_MASK));
				OFS_CTRL: st_d.ctrl = merge(st_q.ctrl, reg_req.addr[0], reg_req.wdata,
					CTRL_MASK);
				default: ;
			endcase
		end
		if (reg_req.rd) begin
			case (word)
				OFS_THR1: st_d.rdata = st_q.thr[0];
				OFS_THR2: st_d.rdata = st_q.thr[1];
				OFS_CNT1: st_d.rdata = {8'h00, st_q.cnt[0]};
				OFS_CNT2: st_d.rdata = {8'h00, st_q.cnt[1]};
				OFS_CTRL: st_d.rdata = st_q.ctrl;
				OFS_DIAG: st_d.rdata = st_q.flags;
				default: st_d.rdata = RST_VALUE;
			endcase
		end

		// Alarm history: one slot per sample, so the window is count samples long.
		if (sample_tick) begin
			for (int i = 0; i < 2; i++) begin
				st_d.hist[i][st_q.wp] = alm_cur[i];
			end
			st_d.wp = st_q.wp + CNT_W'(1);
			st_d.alarm = alm_now;
			set[FL_ALM1 +: 2] = alm_now;
			set[FL_MEM] = st_q.mem_fail;
			set[FL_SELF] = err_cond.self_test;
			set[FL_OVR] = err_cond.overrange;
			set[FL_COMM] = err_cond.comm;
			set[FL_FLASH] = err_cond.flash_update;
			set[FL_SUP_HI] = st_q.sup[FL_SUP_HI];
			set[FL_SUP_LO] = st_q.sup[FL_SUP_LO];
		end

		// Memory checksum walk; data for an index lands one cycle later.
		case (st_q.mt)
			MT_IDLE: begin
				if (memtest_request) begin
					st_d.mt_bit = 1'b1;
					st_d.idx = '0;
					st_d.sum_flash = '0;
					st_d.sum_sram = '0;
					st_d.mt = MT_RUN;
				end
			end
			MT_RUN: begin
				if (st_q.idx != '0) begin
					st_d.sum_flash = st_q.sum_flash + flash_word;
					st_d.sum_sram = st_q.sum_sram + sram_word;
				end
				if (st_q.idx == MEM_LAST) begin
					st_d.mt = MT_LAST;
				end else begin
					st_d.idx = st_q.idx + MEM_AW'(1);
				end
			end
			MT_LAST: begin
				st_d.sum_flash = st_q.sum_flash + flash_word;
				st_d.sum_sram = st_q.sum_sram + sram_word;
				st_d.mt = MT_DONE;
			end
			MT_DONE: begin
				st_d.mem_fail = (st_q.sum_flash != st_q.sum_sram);
				set[FL_MEM] = st_d.mem_fail;
				st_d.mt_bit = 1'b0;
				st_d.mt = MT_IDLE;
			end
			default: st_d.mt = MT_IDLE;
		endcase

		// Read clears everything; a new set in the same cycle still wins.
		st_d.flags = diag_read ? '0 : st_q.flags;
		st_d.flags[FL_SUP_HI] = st_d.flags[FL_SUP_HI] & st_q.sup[FL_SUP_HI];
		st_d.flags[FL_SUP_LO] = st_d.flags[FL_SUP_LO] & st_q.sup[FL_SUP_LO];
		st_d.flags = (st_d.flags | set) & FLAGS_MASK;

		// Indicator routing; an unselected line is released.
		st_d.a_oe = en && !st_q.ctrl[CTL_SEL];
		st_d.b_oe = en && st_q.ctrl[CTL_SEL];
		st_d.a_out = st_d.a_oe && ind_lvl;
		st_d.b_out = st_d.b_oe && ind_lvl;
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign reg_rdata = st_q.rdata;
	assign memtest_bit = st_q.mt_bit;
	assign mem_addr = st_q.idx;
	assign line_a_out = st_q.a_out;
	assign line_a_oe = st_q.a_oe;
	assign line_b_out = st_q.b_out;
	assign line_b_oe = st_q.b_oe;

	// ==========================================================
	// Checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rstn);

	sequence s_test_start;
		st_q.mt == MT_IDLE && memtest_request;
	endsequence
	sequence s_test_end;
		st_q.mt == MT_DONE;
	endsequence

	chk_memtest_span: assert property (
		s_test_start |-> ##[MT_SPAN:MT_SPAN] s_test_end)
		else $error("memory test did not finish on time");
	chk_memtest_autoclear: assert property (
		s_test_end |=> !memtest_bit && st_q.mt == MT_IDLE)
		else $error("memory-test bit not cleared after completion");
	chk_memtest_verdict: assert property (
		s_test_end |=> (st_q.mem_fail == ($past(st_q.sum_flash) != $past(st_q.sum_sram)))
		&& (!st_q.mem_fail || st_q.flags[FL_MEM]))
		else $error("checksum verdict wrong");
	chk_read_clears: assert property (
		diag_read && !sample_tick && st_q.mt != MT_DONE |=> st_q.flags == '0)
		else $error("status read did not clear flags");
	chk_flag_returns: assert property (
		sample_tick && st_q.mem_fail |=> st_q.flags[FL_MEM])
		else $error("persisting memory error not flagged again");
	chk_supply_autoclear: assert property (
		!st_q.sup[FL_SUP_LO] |=> !st_q.flags[FL_SUP_LO])
		else $error("low-supply flag stayed set in range");
	chk_supply_follow: assert property (
		st_q.sync[1][FL_SUP_HI] == st_q.sync[2][FL_SUP_HI]
		|=> st_q.sup[FL_SUP_HI] == $past(st_q.sync[2][FL_SUP_HI]))
		else $error("supply level not taken after agreement");
	chk_alarm_status: assert property (
		sample_tick |=> st_q.flags[FL_ALM1] || !st_q.alarm[0])
		else $error("active alarm 1 not in status");
	chk_overrange_flag: assert property (
		sample_tick && err_cond.overrange |=> st_q.flags[FL_OVR])
		else $error("overrange not flagged");
	chk_unused_source: assert property (
		sample_tick && !src_used(alm_src[0]) |=> !st_q.alarm[0])
		else $error("alarm fired with unused source");
	chk_indicator_off: assert property (
		!st_q.ctrl[CTL_EN] |=> !line_a_oe && !line_b_oe)
		else $error("indicator driven while disabled");
	chk_indicator_level: assert property (
		st_q.ctrl[CTL_EN] && st_q.ctrl[CTL_SEL]
		|=> line_b_oe && !line_a_oe && line_b_out == $past(ind_lvl))
		else $error("indicator level or routing wrong");
endmodule // diag_status_alarm_monitor

`default_nettype wire

// ---- mem_model.sv ----
// Purpose: Flash and SRAM responder for the memory checksum test.
// Assumes: Both memories answer one cycle after the word index.
// Notes: Corrupt flips one SRAM bit so the two checksums disagree.
`timescale 1ns/100ps
`default_nettype none
module mem_model #(
	parameter int AW = 2 // Word index width.
) (
	input wire logic clock, // Sampling clock.
	input wire logic [AW-1:0] mem_addr, // Word index from the block.
	input wire logic corrupt, // Make the SRAM copy differ.
	output logic [15:0] flash_word, // Flash word, one cycle late.
	output logic [15:0] sram_word // SRAM word, one cycle late.
);
	// ==========================================================
	// Memory contents
	// A pattern that differs per word keeps a stuck index from matching by luck.
	always_ff @(posedge clock) begin
		flash_word <= 16'(mem_addr) * 16'h1357 + 16'h2468;
		// Only word 0 is disturbed: flipping bit 0 of every word would cancel in the sum.
		sram_word <= (16'(mem_addr) * 16'h1357 + 16'h2468)
			^ {15'h0000, corrupt && mem_addr == '0};
	end
endmodule // mem_model
`default_nettype wire

// ---- testbench.sv ----
// Purpose: Self-checking bench for the diagnostic flags and alarm monitor.
// Assumes: Inputs change at the falling edge; reads answer one cycle later.
// Notes: The checksum covers four words to keep the run short.
`timescale 1ns/100ps
`default_nettype none
module testbench;
	import diag_alarm_pkg::*;
	localparam int WORDS = 4;
	logic clock = 1'b0;
	logic rstn = 1'b0;
	logic sample_tick = 1'b0;
	logic memtest_request = 1'b0;
	logic supply_high_pin = 1'b0;
	logic supply_low_pin = 1'b0;
	logic corrupt = 1'b0;
	reg_req_t reg_req = '0;
	err_cond_t err_cond = '0;
	sample_set_t raw_samples = '0;
	sample_set_t filt_samples = '0;
	logic [15:0] reg_rdata, flash_word, sram_word, rv, t1, t2, c;
	logic [1:0] mem_addr;
	logic memtest_bit, line_a_out, line_a_oe, line_b_out, line_b_oe, a1, a2, lvl;
	logic [63:0] r64;
	int bad_count = 0;
	int num_checks = 0;
	int hi;
	integer seed = 32'h3A4B2337;
	logic [6:0] ofs [6] = '{OFS_THR1, OFS_THR2, OFS_CNT1, OFS_CNT2, OFS_CTRL, 7'h30};
	logic [15:0] msk [6] = '{THR_MASK, THR_MASK, CNT_MASK, CNT_MASK, CTRL_MASK, 16'h0000};
	always #2 clock = ~clock;
	diag_status_alarm_monitor #(.MEM_WORDS(WORDS)) i_dut (.clock(clock), .rstn(rstn),
		.sample_tick(sample_tick), .reg_req(reg_req), .reg_rdata(reg_rdata),
		.memtest_request(memtest_request), .memtest_bit(memtest_bit), .mem_addr(mem_addr),
		.flash_word(flash_word), .sram_word(sram_word), .supply_high_pin(supply_high_pin),
		.supply_low_pin(supply_low_pin), .err_cond(err_cond), .raw_samples(raw_samples),
		.filt_samples(filt_samples), .line_a_out(line_a_out), .line_a_oe(line_a_oe),
		.line_b_out(line_b_out), .line_b_oe(line_b_oe));
	mem_model #(.AW(2)) i_mem (.clock(clock), .mem_addr(mem_addr), .corrupt(corrupt),
		.flash_word(flash_word), .sram_word(sram_word));
	// ==========================================================
	// Checking and bus tasks
	task automatic check16(input string what, input logic [15:0] exp, input logic [15:0] got);
		num_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic wr_byte(input logic [6:0] a, input logic [7:0] d);
		@(negedge clock);
		reg_req.addr = a;
		reg_req.wdata = d;
		reg_req.wr = 1'b1;
		@(negedge clock);
		reg_req.wr = 1'b0;
	endtask
	task automatic wr16(input logic [6:0] a, input logic [15:0] d);
		wr_byte(a, d[7:0]);
		wr_byte(a | 7'h01, d[15:8]);
	endtask
	task automatic rd16(input logic [6:0] a, output logic [15:0] d);
		@(negedge clock);
		reg_req.addr = a;
		reg_req.rd = 1'b1;
		@(negedge clock);
		reg_req.rd = 1'b0;
		d = reg_rdata;
	endtask
	task automatic tick();
		@(negedge clock);
		sample_tick = 1'b1;
		@(negedge clock);
		sample_tick = 1'b0;
		repeat (2) @(negedge clock);
	endtask
	task automatic memtest(input logic bad);
		int i;
		corrupt = bad;
		hi = 0;
		@(negedge clock);
		memtest_request = 1'b1;
		@(negedge clock);
		memtest_request = 1'b0;
		for (i = 0; i < 40 && memtest_bit === 1'b1; i++) begin
			hi++;
			memtest_request = (i == 2);
			@(negedge clock);
		end
		memtest_request = 1'b0;
		if (i == 40) begin
			bad_count++;
			complete_run();
		end
		repeat (3) @(negedge clock);
		corrupt = 1'b0;
	endtask
	// ==========================================================
	// Expected values
	function automatic logic [13:0] pick(input sample_set_t s, input logic [2:0] src);
		case (src)
			SRC_SUPPLY: return s.supply;
			SRC_GYRO: return s.gyro;
			SRC_AUX: return s.aux;
			SRC_TEMP: return s.temp;
			default: return 14'h0000;
		endcase
	endfunction
	function automatic logic static_exp(input logic [2:0] src, input logic [15:0] thr,
		input logic [13:0] v);
		logic gt, lt;
		gt = (src == SRC_GYRO || src == SRC_TEMP) ? $signed(v) > $signed(thr[13:0]) : v > thr[13:0];
		lt = (src == SRC_GYRO || src == SRC_TEMP) ? $signed(v) < $signed(thr[13:0]) : v < thr[13:0];
		return (src inside {SRC_SUPPLY, SRC_GYRO, SRC_AUX, SRC_TEMP}) && (thr[15] ? gt : lt);
	endfunction
	// ==========================================================
	// Main sequence
	initial begin
		repeat (12) @(negedge clock);
		rstn = 1'b1;
		for (int i = 0; i < 6; i++) begin
			rd16(ofs[i], rv);
			check16("reset value", 16'h0000, rv);
			wr16(ofs[i], 16'hFFFF);
			rd16(ofs[i], rv);
			check16("register mask", msk[i], rv);
			wr16(ofs[i], 16'h0000);
		end
		wr16(OFS_DIAG, 16'hFFFF);
		rd16(OFS_DIAG, rv);
		check16("status after write", 16'h0000, rv);
		$display("test registers finished");
		memtest(1'b1);
		check16("memtest busy cycles", 16'(WORDS + 2), 16'(hi));
		check16("memtest bit idle", 16'h0000, {15'h0000, memtest_bit});
		rd16(OFS_DIAG, rv);
		check16("checksum fail flag", 16'h0040, rv);
		rd16(OFS_DIAG, rv);
		check16("flag cleared by read", 16'h0000, rv);
		tick();
		rd16(OFS_DIAG, rv);
		check16("checksum flag again", 16'h0040, rv);
		memtest(1'b0);
		tick();
		rd16(OFS_DIAG, rv);
		check16("checksum pass flag", 16'h0000, rv);
		$display("test memory finished");
		for (int k = 0; k < 4; k++) begin
			err_cond = err_cond_t'(4'h1 << k);
			tick();
			rd16(OFS_DIAG, rv);
			check16("error flag", 16'h0004 << k, rv);
			rd16(OFS_DIAG, rv);
			check16("error flag read", 16'h0000, rv);
			tick();
			rd16(OFS_DIAG, rv);
			check16("error flag persists", 16'h0004 << k, rv);
		end
		err_cond = '0;
		for (int j = 0; j < 2; j++) begin
			{supply_high_pin, supply_low_pin} = 2'b10 >> j;
			repeat (6) @(negedge clock);
			tick();
			rd16(OFS_DIAG, rv);
			check16("supply flag", 16'h0002 >> j, rv);
			tick();
			{supply_high_pin, supply_low_pin} = 2'b00;
			repeat (6) @(negedge clock);
			rd16(OFS_DIAG, rv);
			check16("supply flag drop", 16'h0000, rv);
		end
		$display("test status finished");
		for (int i = 0; i < 32; i++) begin
			r64 = {$random(seed), $random(seed)};
			raw_samples = r64[55:0];
			r64 = {$random(seed), $random(seed)};
			filt_samples = r64[55:0];
			c = 16'($random(seed)) & CTRL_MASK;
			t1 = 16'($random(seed));
			t2 = 16'($random(seed));
			c[15] = 1'b0;
			c[11] = 1'b0;
			if (i >= 8 && i < 12) begin
				c[10:8] = SRC_GYRO;
				raw_samples.gyro = t1[13:0];
				filt_samples.gyro = t1[13:0];
			end
			if (i < 8) c[10:8] = 3'(i);
			wr16(OFS_CTRL, c);
			wr16(OFS_THR1, t1);
			wr16(OFS_THR2, t2);
			tick();
			a1 = static_exp(c[10:8], t1, pick(c[4] ? filt_samples : raw_samples, c[10:8]));
			a2 = static_exp(c[14:12], t2, pick(c[4] ? filt_samples : raw_samples, c[14:12]));
			lvl = c[1] ? (a1 | a2) : ~(a1 | a2);
			check16("indicator lines", {12'h000, c[2] & ~c[0], c[2] & ~c[0] & lvl,
				c[2] & c[0], c[2] & c[0] & lvl},
				{12'h000, line_a_oe, line_a_out, line_b_oe, line_b_out});
			rd16(OFS_DIAG, rv);
			check16("static alarm flags", {6'h00, a2, a1, 8'h00}, rv);
		end
		$display("test static alarms finished");
		raw_samples.aux = 14'd100;
		wr16(OFS_CTRL, 16'hDD07);
		wr16(OFS_CNT1, 16'hFF00);
		wr16(OFS_CNT2, 16'h0002);
		wr16(OFS_THR1, 16'h800A);
		wr16(OFS_THR2, 16'h000A);
		repeat (3) tick();
		rd16(OFS_DIAG, rv);
		raw_samples.aux = 14'd150;
		for (int s = 0; s < 3; s++) begin
			tick();
			if (s == 0) check16("rate indicator", 16'h0001, {15'h0000, line_b_out});
			rd16(OFS_DIAG, rv);
			check16("rate alarm flags", (s == 0) ? 16'h0100 : (s == 1) ? 16'h0000 : 16'h0200, rv);
		end
		$display("test rate alarms finished");
		complete_run();
	end
endmodule // testbench
`default_nettype wire
